// ===== hdl/adc_engine_cfg.svh
// Register offsets, field positions, reset values and counts of the ADC timing engine
`ifndef ADC_ENGINE_CFG_SVH
`define ADC_ENGINE_CFG_SVH

// Register offsets on the host register port
`define LIMIT_HIGH_UPPER_ADDR 8'h63
`define LIMIT_HIGH_LOWER_ADDR 8'h64
`define LIMIT_LOW_UPPER_ADDR 8'h65
`define LIMIT_LOW_LOWER_ADDR 8'h66
`define TRIGGER_CONFIG_ADDR 8'h67
`define ACCUMULATOR_UPPER_ADDR 8'h94
`define ACCUMULATOR_LOWER_ADDR 8'h95
`define PEAK_UPPER_ADDR 8'h96
`define PEAK_LOWER_ADDR 8'h97
`define TROUGH_UPPER_ADDR 8'h98
`define TROUGH_LOWER_ADDR 8'h99
`define CONVERSION_STATUS_ADDR 8'h9A
`define ENGINE_SETUP_ADDR 8'h61
`define SUMMARY_STATUS_ADDR 8'h8C

// Engine setup fields
`define SETUP_ENABLE_BIT 7
`define SETUP_REPEAT_BIT 3
`define SETUP_MODE_HI 1
`define SETUP_MODE_LO 0

// Trigger configuration fields
`define TRIG_PIN_B_BIT 7
`define TRIG_PIN_A_BIT 6
`define TRIG_HOLDOFF_BIT 5

// Conversion status fields
`define STAT_DONE_BIT 7
`define STAT_ERROR_BIT 6
`define STAT_HIGH_FAULT_BIT 5
`define STAT_LOW_FAULT_BIT 4
`define STAT_PIN_B_BIT 1
`define STAT_PIN_A_BIT 0

// Summary status fields
`define SUMMARY_BUSY_BIT 1
`define SUMMARY_INT_BIT 0

// Reset values
`define LIMIT_HIGH_RESET 12'hFFF
`define LIMIT_LOW_RESET 12'h000
`define SETUP_RESET 8'h00
`define TRIGGER_CONFIG_RESET 8'h00

// Sample counts and average shifts per read mode
`define SAMPLES_MODE_SINGLE 7'h01
`define SAMPLES_MODE_16 7'h10
`define SAMPLES_MODE_32 7'h20
`define SAMPLES_MODE_64 7'h40
`define SHIFT_MODE_16 3'h2
`define SHIFT_MODE_32 3'h3
`define SHIFT_MODE_64 3'h4

`endif

// ===== hdl/adc_engine_pkg.sv
// Types and shared helper functions of the ADC timing engine
`include "adc_engine_cfg.svh"

package adc_engine_pkg;

	// Read mode: single sample or averaged multi-sample cycle
	typedef enum logic [1:0] {
		MODE_SINGLE = 2'h0,
		MODE_AVG16 = 2'h1,
		MODE_AVG32 = 2'h2,
		MODE_AVG64 = 2'h3
	} read_mode_t;

	// Sequencer states, one-hot
	typedef enum logic [4:0] {
		ST_IDLE = 5'h01,
		ST_ARMED = 5'h02,
		ST_START = 5'h04,
		ST_WAIT = 5'h08,
		ST_FINISH = 5'h10
	} engine_state_t;

	// Trigger source selection and pin polarity
	typedef struct packed {
		logic sel_a;
		logic sel_b;
		logic inv_a;
		logic inv_b;
		logic holdoff;
	} trigger_cfg_t;

	// ALU results of one conversion cycle
	typedef struct packed {
		logic [15:0] sum;
		logic [9:0] peak;
		logic [9:0] trough;
	} alu_result_t;

	// Number of conversions in one cycle
	function automatic logic [6:0] samples_for_mode(input read_mode_t mode);
		case (mode)
			MODE_AVG16: samples_for_mode = `SAMPLES_MODE_16;
			MODE_AVG32: samples_for_mode = `SAMPLES_MODE_32;
			MODE_AVG64: samples_for_mode = `SAMPLES_MODE_64;
			default: samples_for_mode = `SAMPLES_MODE_SINGLE;
		endcase
	endfunction

	// Twelve-bit average from the accumulator
	function automatic logic [11:0] average_of(input read_mode_t mode, input logic [15:0] sum);
		logic [15:0] shifted;
		shifted = 16'h0000;
		case (mode)
			MODE_AVG16: shifted = sum >> `SHIFT_MODE_16;
			MODE_AVG32: shifted = sum >> `SHIFT_MODE_32;
			MODE_AVG64: shifted = sum >> `SHIFT_MODE_64;
			default: shifted = sum;
		endcase
		average_of = shifted[11:0];
	endfunction

endpackage

// ===== hdl/trigger_detect.sv
// Pin synchroniser, polarity, edge detect and holdoff gate for the external triggers
`timescale 1ns/1ps
`default_nettype none

module trigger_detect (
	input wire logic i_core_clk,
	input wire logic i_rst_n,
	input wire logic i_pin_a,
	input wire logic i_pin_b,
	input wire adc_engine_pkg::trigger_cfg_t i_cfg,
	output logic o_start,
	output logic o_suspend,
	output logic o_level_a,
	output logic o_level_b
);

	// Three-stage synchronisers, one per pin
	logic [2:0] sync_a_reg;
	logic [2:0] sync_b_reg;
	// Filtered pin levels and their previous values
	logic level_a_reg;
	logic level_b_reg;
	logic prev_a_reg;
	logic prev_b_reg;
	// Pin levels after polarity, high meaning active
	logic act_a;
	logic act_b;
	logic prev_act_a;
	logic prev_act_b;

	// Shift pins into the synchronisers
	always_ff @(posedge i_core_clk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			sync_a_reg <= 3'h0;
			sync_b_reg <= 3'h0;
		end else begin
			sync_a_reg <= {sync_a_reg[1:0], i_pin_a};
			sync_b_reg <= {sync_b_reg[1:0], i_pin_b};
		end
	end

	// A level change counts once stages two and three agree
	always_ff @(posedge i_core_clk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			level_a_reg <= 1'b0;
			level_b_reg <= 1'b0;
			prev_a_reg <= 1'b0;
			prev_b_reg <= 1'b0;
		end else begin
			if (sync_a_reg[1] == sync_a_reg[2]) begin
				level_a_reg <= sync_a_reg[2];
			end
			if (sync_b_reg[1] == sync_b_reg[2]) begin
				level_b_reg <= sync_b_reg[2];
			end
			prev_a_reg <= level_a_reg;
			prev_b_reg <= level_b_reg;
		end
	end

	// Inverted pins are active low
	assign act_a = level_a_reg ^ i_cfg.inv_a;
	assign act_b = level_b_reg ^ i_cfg.inv_b;
	assign prev_act_a = prev_a_reg ^ i_cfg.inv_a;
	assign prev_act_b = prev_b_reg ^ i_cfg.inv_b;

	// Rising edge of active level, falling pin edge when inverted, either pin if both chosen
	assign o_start = (i_cfg.sel_a && act_a && !prev_act_a) ||
		(i_cfg.sel_b && act_b && !prev_act_b);

	// Suspend only while every selected pin sits inactive
	assign o_suspend = i_cfg.holdoff && (i_cfg.sel_a || i_cfg.sel_b) &&
		!(i_cfg.sel_a && act_a) && !(i_cfg.sel_b && act_b);

	assign o_level_a = level_a_reg;
	assign o_level_b = level_b_reg;

endmodule

`default_nettype wire

// ===== hdl/sample_alu.sv
// Accumulator and peak/trough tracker for one conversion cycle
`timescale 1ns/1ps
`default_nettype none

module sample_alu #(
	parameter int SAMPLE_W = 10,
	parameter int SUM_W = 16
) (
	input wire logic i_core_clk,
	input wire logic i_rst_n,
	input wire logic i_clear,
	input wire logic i_valid,
	input wire logic [SAMPLE_W-1:0] i_sample,
	output logic [SUM_W-1:0] o_sum,
	output logic [SAMPLE_W-1:0] o_peak,
	output logic [SAMPLE_W-1:0] o_trough
);

	// Running sum, largest and smallest sample
	logic [SUM_W-1:0] sum_reg;
	logic [SAMPLE_W-1:0] peak_reg;
	logic [SAMPLE_W-1:0] trough_reg;
	// Set once the first sample of the cycle is in
	logic seen_reg;

	// Clear at cycle start, fold in each sample
	always_ff @(posedge i_core_clk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			sum_reg <= '0;
			peak_reg <= '0;
			trough_reg <= '0;
			seen_reg <= 1'b0;
		end else if (i_clear) begin
			// Results reflect only the new cycle
			sum_reg <= '0;
			peak_reg <= '0;
			trough_reg <= '0;
			seen_reg <= 1'b0;
		end else if (i_valid) begin
			sum_reg <= sum_reg + SUM_W'(i_sample);
			seen_reg <= 1'b1;
			// Peak and trough detection
			if (!seen_reg || i_sample > peak_reg) begin
				peak_reg <= i_sample;
			end
			if (!seen_reg || i_sample < trough_reg) begin
				trough_reg <= i_sample;
			end
		end
	end

	assign o_sum = sum_reg;
	assign o_peak = peak_reg;
	assign o_trough = trough_reg;

endmodule

`default_nettype wire

// ===== hdl/adc_trigger_alu_limit_engine.sv
// Sequencer, limit check and host registers of the ADC timing engine
//
// Summary of operation
// - Start on active edge of selected pins
// - Holdoff suspends while all selected pins inactive
// - Enable after selection arms, waits for trigger
// - Armed engine waits forever, no timeout
// - Sixteen-bit sum, ten-bit peak and trough
// - Sample counts are full-scale 1023 codes
// - Fault and interrupt on limit crossing
// - Limits 0x000 and 0xFFF never fault
// - Mode 00 with repeat checks each sample
// - Repeat restarts until fault or disable
// - Averaged modes with repeat check average at cycle end
// - Average is sum shifted by 2, 3, 4
// - Status read-only; reading clears interrupt bit
// - Status bits: done, error, faults, pin levels
// - ALU does sum and peak/trough
`timescale 1ns/1ps
`default_nettype none
`include "adc_engine_cfg.svh"

module adc_trigger_alu_limit_engine #(
	parameter int SAMPLE_W = 10,
	parameter int SUM_W = 16
) (
	input wire logic i_core_clk,
	input wire logic i_rst_n,
	// Register port from the serial host interface
	input wire logic i_reg_wr,
	input wire logic i_reg_rd,
	input wire logic [7:0] i_reg_addr,
	input wire logic [7:0] i_reg_wdata,
	output logic [7:0] o_reg_rdata,
	// Trigger pins and their input polarity
	input wire logic i_trigger_pin_a,
	input wire logic i_trigger_pin_b,
	input wire logic i_pin_a_inverted,
	input wire logic i_pin_b_inverted,
	// Converter handshake
	output logic o_conv_start,
	input wire logic i_conv_done,
	input wire logic i_conv_error,
	input wire logic [SAMPLE_W-1:0] i_conv_data,
	// Status towards the rest of the device
	output logic o_engine_busy,
	output logic o_engine_irq
);

	// Host-written registers
	logic [11:0] upper_threshold_reg;
	logic [11:0] lower_threshold_reg;
	logic [7:0] engine_setup_reg;
	logic [7:0] trigger_config_reg;
	// Sequencer state and sample counter
	adc_engine_pkg::engine_state_t state_reg;
	adc_engine_pkg::engine_state_t state_next;
	logic [6:0] count_reg;
	// Status flags
	logic cycle_complete_flag;
	logic conversion_error_flag;
	logic upper_threshold_fault;
	logic lower_threshold_fault;
	logic pin_a_level_at_end;
	logic pin_b_level_at_end;
	logic engine_interrupt_bit;
	// Registered outputs
	logic conv_start_reg;
	logic [7:0] rdata_reg;

	// Decoded setup fields
	logic engine_enable;
	logic repeat_en;
	adc_engine_pkg::read_mode_t read_mode;
	adc_engine_pkg::trigger_cfg_t trig_cfg;
	logic external_sel;
	// Trigger detector outputs
	logic trig_start;
	logic trig_suspend;
	logic level_a;
	logic level_b;
	// ALU results
	adc_engine_pkg::alu_result_t alu;
	// Cycle events
	logic setup_write;
	logic enable_rise;
	logic enable_fall;
	logic status_read;
	logic cycle_clear;
	logic last_sample;
	logic sample_high;
	logic sample_low;
	logic [11:0] average;
	logic avg_high;
	logic avg_low;
	logic high_hit;
	logic low_hit;
	logic violation;

	// Setup field decode
	assign engine_enable = engine_setup_reg[`SETUP_ENABLE_BIT];
	assign repeat_en = engine_setup_reg[`SETUP_REPEAT_BIT];
	assign read_mode = adc_engine_pkg::read_mode_t'(
		engine_setup_reg[`SETUP_MODE_HI:`SETUP_MODE_LO]);
	assign trig_cfg.sel_a = trigger_config_reg[`TRIG_PIN_A_BIT];
	assign trig_cfg.sel_b = trigger_config_reg[`TRIG_PIN_B_BIT];
	assign trig_cfg.holdoff = trigger_config_reg[`TRIG_HOLDOFF_BIT];
	assign trig_cfg.inv_a = i_pin_a_inverted;
	assign trig_cfg.inv_b = i_pin_b_inverted;
	// With neither pin chosen the internal trigger starts the cycle
	assign external_sel = trig_cfg.sel_a || trig_cfg.sel_b;

	// Host access events
	assign setup_write = i_reg_wr && (i_reg_addr == `ENGINE_SETUP_ADDR);
	assign enable_rise = setup_write && i_reg_wdata[`SETUP_ENABLE_BIT] && !engine_enable;
	assign enable_fall = setup_write && !i_reg_wdata[`SETUP_ENABLE_BIT];
	assign status_read = i_reg_rd && (i_reg_addr == `CONVERSION_STATUS_ADDR);

	// External trigger front end
	trigger_detect u_trigger_detect (
		.i_core_clk(i_core_clk),
		.i_rst_n(i_rst_n),
		.i_pin_a(i_trigger_pin_a),
		.i_pin_b(i_trigger_pin_b),
		.i_cfg(trig_cfg),
		.o_start(trig_start),
		.o_suspend(trig_suspend),
		.o_level_a(level_a),
		.o_level_b(level_b)
	);

	// Accumulator and trackers; each sample is already a 0..1023 code
	sample_alu #(
		.SAMPLE_W(SAMPLE_W),
		.SUM_W(SUM_W)
	) u_sample_alu (
		.i_core_clk(i_core_clk),
		.i_rst_n(i_rst_n),
		.i_clear(cycle_clear),
		.i_valid(state_reg == adc_engine_pkg::ST_WAIT && i_conv_done),
		.i_sample(i_conv_data),
		.o_sum(alu.sum),
		.o_peak(alu.peak),
		.o_trough(alu.trough)
	);

	// A new cycle begins on a trigger in the armed state or on an internal start
	assign cycle_clear = (state_reg == adc_engine_pkg::ST_ARMED && trig_start) ||
		(state_reg == adc_engine_pkg::ST_IDLE && enable_rise && !external_sel) ||
		(state_reg == adc_engine_pkg::ST_FINISH && state_next == adc_engine_pkg::ST_START);

	assign last_sample = (count_reg + 7'h01) >= adc_engine_pkg::samples_for_mode(read_mode);

	// Single-sample mode compares each ten-bit sample against twelve-bit limits
	assign sample_high = {2'b00, i_conv_data} > upper_threshold_reg;
	assign sample_low = {2'b00, i_conv_data} < lower_threshold_reg;

	// Averaged modes compare the shifted sum at cycle end
	assign average = adc_engine_pkg::average_of(read_mode, alu.sum);
	assign avg_high = average > upper_threshold_reg;
	assign avg_low = average < lower_threshold_reg;

	// Fault conditions, taken only when a limit-check sequence runs
	always_comb begin
		high_hit = 1'b0;
		low_hit = 1'b0;
		if (repeat_en) begin
			if (read_mode == adc_engine_pkg::MODE_SINGLE) begin
				// Per-sample check as each result returns
				high_hit = state_reg == adc_engine_pkg::ST_WAIT && i_conv_done && sample_high;
				low_hit = state_reg == adc_engine_pkg::ST_WAIT && i_conv_done && sample_low;
			end else begin
				// Average check once the cycle is complete
				high_hit = state_reg == adc_engine_pkg::ST_FINISH && avg_high;
				low_hit = state_reg == adc_engine_pkg::ST_FINISH && avg_low;
			end
		end
	end
	assign violation = high_hit || low_hit;

	// Next-state logic of the sequencer
	always_comb begin
		state_next = state_reg;
		case (state_reg)
			adc_engine_pkg::ST_IDLE: begin
				if (enable_rise) begin
					// Enable after selecting a pin arms the engine
					state_next = external_sel ? adc_engine_pkg::ST_ARMED
						: adc_engine_pkg::ST_START;
				end
			end
			adc_engine_pkg::ST_ARMED: begin
				// No timeout: only a trigger or a disable leaves this state
				if (trig_start) begin
					state_next = adc_engine_pkg::ST_START;
				end
			end
			adc_engine_pkg::ST_START: begin
				// Holdoff gate holds the next conversion back
				if (!trig_suspend) begin
					state_next = adc_engine_pkg::ST_WAIT;
				end
			end
			adc_engine_pkg::ST_WAIT: begin
				if (i_conv_done) begin
					state_next = last_sample ? adc_engine_pkg::ST_FINISH
						: adc_engine_pkg::ST_START;
				end
			end
			adc_engine_pkg::ST_FINISH: begin
				// Repeat restarts until a fault stops it
				if (repeat_en && !violation && !(high_hit_seen() || low_hit_seen())) begin
					state_next = external_sel ? adc_engine_pkg::ST_ARMED
						: adc_engine_pkg::ST_START;
				end else begin
					state_next = adc_engine_pkg::ST_IDLE;
				end
			end
			default: begin
				state_next = adc_engine_pkg::ST_IDLE;
			end
		endcase
		// Writing enable low stops any sequence at once
		if (enable_fall) begin
			state_next = adc_engine_pkg::ST_IDLE;
		end
	end

	// A per-sample fault earlier in this cycle also ends the repeat
	function automatic logic high_hit_seen();
		high_hit_seen = repeat_en && read_mode == adc_engine_pkg::MODE_SINGLE &&
			upper_threshold_fault;
	endfunction

	function automatic logic low_hit_seen();
		low_hit_seen = repeat_en && read_mode == adc_engine_pkg::MODE_SINGLE &&
			lower_threshold_fault;
	endfunction

	// Sequencer state register
	always_ff @(posedge i_core_clk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			state_reg <= adc_engine_pkg::ST_IDLE;
		end else begin
			state_reg <= state_next;
		end
	end

	// Sample counter within a cycle
	always_ff @(posedge i_core_clk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			count_reg <= 7'h00;
		end else if (cycle_clear) begin
			count_reg <= 7'h00;
		end else if (state_reg == adc_engine_pkg::ST_WAIT && i_conv_done) begin
			count_reg <= count_reg + 7'h01;
		end
	end

	// One-cycle start request to the converter
	always_ff @(posedge i_core_clk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			conv_start_reg <= 1'b0;
		end else begin
			conv_start_reg <= state_reg == adc_engine_pkg::ST_START &&
				state_next == adc_engine_pkg::ST_WAIT;
		end
	end

	// Host-writable limit registers
	always_ff @(posedge i_core_clk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			upper_threshold_reg <= `LIMIT_HIGH_RESET;
			lower_threshold_reg <= `LIMIT_LOW_RESET;
		end else if (i_reg_wr) begin
			case (i_reg_addr)
				`LIMIT_HIGH_UPPER_ADDR: upper_threshold_reg[11:8] <= i_reg_wdata[3:0];
				`LIMIT_HIGH_LOWER_ADDR: upper_threshold_reg[7:0] <= i_reg_wdata;
				`LIMIT_LOW_UPPER_ADDR: lower_threshold_reg[11:8] <= i_reg_wdata[3:0];
				`LIMIT_LOW_LOWER_ADDR: lower_threshold_reg[7:0] <= i_reg_wdata;
				default: begin
				end
			endcase
		end
	end

	// Host-writable setup and trigger configuration
	always_ff @(posedge i_core_clk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			engine_setup_reg <= `SETUP_RESET;
			trigger_config_reg <= `TRIGGER_CONFIG_RESET;
		end else if (i_reg_wr) begin
			case (i_reg_addr)
				`ENGINE_SETUP_ADDR: engine_setup_reg <= i_reg_wdata;
				`TRIGGER_CONFIG_ADDR: trigger_config_reg <= i_reg_wdata;
				default: begin
				end
			endcase
		end
	end

	// Done and error flags, cleared when a new cycle begins
	always_ff @(posedge i_core_clk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			cycle_complete_flag <= 1'b0;
			conversion_error_flag <= 1'b0;
		end else if (cycle_clear) begin
			cycle_complete_flag <= 1'b0;
			conversion_error_flag <= 1'b0;
		end else begin
			if (state_reg == adc_engine_pkg::ST_FINISH) begin
				cycle_complete_flag <= 1'b1;
			end
			if (state_reg == adc_engine_pkg::ST_WAIT && i_conv_done && i_conv_error) begin
				conversion_error_flag <= 1'b1;
			end
		end
	end

	// Sticky faults: a new fault in the read cycle wins over the clear
	always_ff @(posedge i_core_clk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			upper_threshold_fault <= 1'b0;
			lower_threshold_fault <= 1'b0;
		end else begin
			if (high_hit) begin
				upper_threshold_fault <= 1'b1;
			end else if (status_read) begin
				upper_threshold_fault <= 1'b0;
			end
			if (low_hit) begin
				lower_threshold_fault <= 1'b1;
			end else if (status_read) begin
				lower_threshold_fault <= 1'b0;
			end
		end
	end

	// Interrupt bit set on cycle end or fault, cleared by a status read
	always_ff @(posedge i_core_clk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			engine_interrupt_bit <= 1'b0;
		end else if (violation || state_reg == adc_engine_pkg::ST_FINISH) begin
			engine_interrupt_bit <= 1'b1;
		end else if (status_read) begin
			engine_interrupt_bit <= 1'b0;
		end
	end

	// Pin levels captured at end of conversion
	always_ff @(posedge i_core_clk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			pin_a_level_at_end <= 1'b0;
			pin_b_level_at_end <= 1'b0;
		end else if (state_reg == adc_engine_pkg::ST_WAIT && i_conv_done) begin
			pin_a_level_at_end <= level_a;
			pin_b_level_at_end <= level_b;
		end
	end

	// Read data, one cycle after the read strobe; status is read-only
	always_ff @(posedge i_core_clk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			rdata_reg <= 8'h00;
		end else if (i_reg_rd) begin
			case (i_reg_addr)
				`LIMIT_HIGH_UPPER_ADDR: rdata_reg <= {4'h0, upper_threshold_reg[11:8]};
				`LIMIT_HIGH_LOWER_ADDR: rdata_reg <= upper_threshold_reg[7:0];
				`LIMIT_LOW_UPPER_ADDR: rdata_reg <= {4'h0, lower_threshold_reg[11:8]};
				`LIMIT_LOW_LOWER_ADDR: rdata_reg <= lower_threshold_reg[7:0];
				`TRIGGER_CONFIG_ADDR: rdata_reg <= trigger_config_reg;
				`ENGINE_SETUP_ADDR: rdata_reg <= engine_setup_reg;
				`ACCUMULATOR_UPPER_ADDR: rdata_reg <= alu.sum[15:8];
				`ACCUMULATOR_LOWER_ADDR: rdata_reg <= alu.sum[7:0];
				`PEAK_UPPER_ADDR: rdata_reg <= {6'h00, alu.peak[9:8]};
				`PEAK_LOWER_ADDR: rdata_reg <= alu.peak[7:0];
				`TROUGH_UPPER_ADDR: rdata_reg <= {6'h00, alu.trough[9:8]};
				`TROUGH_LOWER_ADDR: rdata_reg <= alu.trough[7:0];
				`CONVERSION_STATUS_ADDR: begin
					rdata_reg <= {cycle_complete_flag, conversion_error_flag,
						upper_threshold_fault, lower_threshold_fault, 2'b00,
						pin_b_level_at_end, pin_a_level_at_end};
				end
				`SUMMARY_STATUS_ADDR: begin
					rdata_reg <= {6'h00, state_reg != adc_engine_pkg::ST_IDLE,
						engine_interrupt_bit};
				end
				// Unmapped offsets read as zero
				default: rdata_reg <= 8'h00;
			endcase
		end
	end

	// Busy flag mirrors the sequencer, registered
	always_ff @(posedge i_core_clk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			o_engine_busy <= 1'b0;
		end else begin
			o_engine_busy <= state_next != adc_engine_pkg::ST_IDLE;
		end
	end

	assign o_reg_rdata = rdata_reg;
	assign o_conv_start = conv_start_reg;
	assign o_engine_irq = engine_interrupt_bit;

endmodule

`default_nettype wire

// ===== testbench/adc_engine_sva.sv
// Port-level assertions for the ADC timing engine
`timescale 1ns/1ps
`default_nettype none
module adc_engine_sva (
	input wire logic i_core_clk,
	input wire logic i_rst_n,
	input wire logic i_reg_rd,
	input wire logic [7:0] i_reg_addr,
	input wire logic [7:0] o_reg_rdata,
	input wire logic o_conv_start,
	input wire logic i_conv_done,
	input wire logic o_engine_busy,
	input wire logic o_engine_irq
);
	default clocking @(posedge i_core_clk); endclocking
	default disable iff (!i_rst_n);
	chk_start_pulse: assert property (o_conv_start |=> !o_conv_start)
		else $error("start pulse too long");
	chk_start_busy: assert property (o_conv_start |-> o_engine_busy)
		else $error("start while idle");
	chk_done_gap: assert property (i_conv_done |=> !o_conv_start)
		else $error("restart too soon after result");
	chk_status_clear: assert property (i_reg_rd && i_reg_addr == 8'h9A
		&& !o_engine_busy |=> !o_engine_irq) else $error("status read left interrupt set");
	chk_unmapped_zero: assert property (i_reg_rd && i_reg_addr == 8'h00
		|=> o_reg_rdata == 8'h00) else $error("unmapped read not zero");
	chk_rdata_hold: assert property (!i_reg_rd |=> $stable(o_reg_rdata))
		else $error("read data changed without a read");
	chk_limit_upper: assert property (i_reg_rd && i_reg_addr inside {8'h63, 8'h65}
		|=> o_reg_rdata[7:4] == 4'h0) else $error("limit upper bits set");
	chk_peak_upper: assert property (i_reg_rd && i_reg_addr inside {8'h96, 8'h98}
		|=> o_reg_rdata[7:2] == 6'h00) else $error("tracker wider than ten bits");
	cover property (o_conv_start);
	cover property (i_conv_done ##1 !o_engine_busy);
	cover property (i_reg_rd && i_reg_addr == 8'h9A && o_engine_irq);
endmodule
`default_nettype wire

// ===== testbench/adc_conv_model.sv
// Converter model: answers each start with one result after a varying latency
`timescale 1ns/1ps
`default_nettype none
module adc_conv_model (
	input wire logic i_clk,
	input wire logic i_rst_n,
	input wire logic i_start,
	input wire logic [9:0] i_value,
	output logic o_done,
	output logic [9:0] o_data
);
	int cnt;
	// Latency 3 to 6 cycles; data toggles outside the valid pulse
	always_ff @(posedge i_clk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			cnt <= 0;
			o_done <= 1'b0;
			o_data <= 10'h2AA;
		end else begin
			o_done <= 1'b0;
			o_data <= ~o_data;
			if (i_start) begin
				cnt <= 3 + int'(i_value[1:0]);
			end else if (cnt == 1) begin
				o_done <= 1'b1;
				o_data <= i_value;
				cnt <= 0;
			end else if (cnt > 1) begin
				cnt <= cnt - 1;
			end
		end
	end
endmodule
`default_nettype wire

// ===== testbench/adc_trigger_alu_limit_engine_tb_top.sv
// Self-checking bench for the ADC timing engine
`timescale 1ns/1ps
`default_nettype none
module adc_trigger_alu_limit_engine_tb_top;
	logic clk = 0, rst_n = 0, wr = 0, rd = 0, pa = 1, pb = 0, ia = 0, ib = 0, err = 0;
	logic [7:0] addr = 0, wdata = 0, rdata;
	logic start, done, busy, irq;
	logic [9:0] data, smp = 0;
	int miscompares = 0, samples_checked = 0, lo = 0, span = 1024, nst, sum, pk, tr, i;
	always #20 clk = ~clk;
	adc_trigger_alu_limit_engine dut_u (.i_core_clk(clk), .i_rst_n(rst_n), .i_reg_wr(wr),
		.i_reg_rd(rd), .i_reg_addr(addr), .i_reg_wdata(wdata), .o_reg_rdata(rdata),
		.i_trigger_pin_a(pa), .i_trigger_pin_b(pb), .i_pin_a_inverted(ia),
		.i_pin_b_inverted(ib), .o_conv_start(start), .i_conv_done(done),
		.i_conv_error(err), .i_conv_data(data), .o_engine_busy(busy), .o_engine_irq(irq));
	adc_conv_model conv_u (.i_clk(clk), .i_rst_n(rst_n), .i_start(start), .i_value(smp),
		.o_done(done), .o_data(data));
	// Reference ALU: sum, peak and trough of the current cycle
	always @(posedge clk) begin
		if (start) nst++;
		if (done) begin
			sum = (sum + int'(data)) & 16'hFFFF;
			if (int'(data) > pk) pk = int'(data);
			if (int'(data) < tr) tr = int'(data);
		end
	end
	always @(negedge clk) smp <= 10'(lo + int'($urandom % span));
	task automatic chk(input string n, input logic [15:0] s, e);
		samples_checked++;
		if (s !== e) begin
			miscompares++;
			$display("[ERR] %s exp %h seen %h", n, e, s);
		end
	endtask
	task automatic wr_reg(input logic [7:0] a, d);
		@(negedge clk); wr = 1; addr = a; wdata = d;
		@(negedge clk); wr = 0;
	endtask
	task automatic rc(input logic [7:0] a, e, m = 8'hFF);
		@(negedge clk); rd = 1; addr = a;
		@(negedge clk); rd = 0;
		chk($sformatf("reg %h", a), {8'h00, rdata & m}, {8'h00, e & m});
	endtask
	// Host start order: stop, select trigger, enable
	task automatic arm(input logic [7:0] setup, cfg);
		wr_reg(8'h61, 8'h00);
		wr_reg(8'h67, cfg);
		sum = 0; pk = 0; tr = 1023; nst = 0;
		wr_reg(8'h61, setup);
	endtask
	task automatic fin(input logic [1:0] flt, input logic [7:0] m, input logic er = 1'b0);
		int k;
		k = 0;
		repeat (3) @(negedge clk);
		while (busy !== 1'b0 && k < 9000) begin
			@(negedge clk); k++;
		end
		chk("busy", {15'h0, busy}, 16'h0);
		chk("irq", {15'h0, irq}, 16'h1);
		rc(8'h94, 8'(sum >> 8));
		rc(8'h95, 8'(sum));
		rc(8'h96, 8'(pk >> 8));
		rc(8'h97, 8'(pk));
		rc(8'h98, 8'(tr >> 8));
		rc(8'h99, 8'(tr));
		rc(8'h9A, {1'b1, er, flt, 2'b00, pb, pa}, m);
		chk("irq", {15'h0, irq}, 16'h0);
		rc(8'h9A, {1'b1, er, 4'h0, pb, pa}, m);
	endtask
	task tally_and_finish;
		$display("checked %0d mismatches %0d", samples_checked, miscompares);
		if (miscompares == 0 && samples_checked > 0) $display("TB: PASS");
		else $display("TB: FAIL");
		$finish;
	endtask
	initial begin
		#2000000;
		miscompares++;
		tally_and_finish;
	end
	initial begin
		i = $urandom(63513);
		repeat (3) @(negedge clk);
		rst_n = 1;
		rc(8'h63, 8'h0F); rc(8'h64, 8'hFF); rc(8'h65, 8'h00); rc(8'h66, 8'h00);
		rc(8'h00, 8'h00);
		for (i = 0; i < 4; i++) begin
			arm(8'h80 | 8'(i), 8'h00);
			fin(2'b00, 8'hFF);
		end
		// Pin a plain then pin b inverted: armed engine waits, edge starts
		ia = 0; ib = 1; pa = 0; pb = 1;
		for (i = 0; i < 2; i++) begin
			repeat (8) @(negedge clk);
			arm(8'h80, i ? 8'h80 : 8'h40);
			repeat (60) @(negedge clk);
			chk("starts", 16'(nst), 16'h0);
			chk("busy", {15'h0, busy}, 16'h1);
			if (i) pb = 0; else pa = 1;
			fin(2'b00, 8'hF1);
		end
		// Holdoff: pin a going low stalls a running averaged cycle until it rises
		pa = 0;
		repeat (8) @(negedge clk);
		arm(8'h81, 8'h60);
		pa = 1;
		repeat (30) @(negedge clk);
		pa = 0;
		repeat (12) @(negedge clk);
		i = nst;
		repeat (60) @(negedge clk);
		chk("held", 16'(nst - i), 16'h0);
		pa = 1;
		fin(2'b00, 8'hF1);
		ib = 0;
		// Per-sample low fault with a converter error, then averaged high fault
		wr_reg(8'h65, 8'h02); span = 512;
		err = 1;
		arm(8'h88, 8'h00);
		fin(2'b01, 8'hFF, 1'b1);
		err = 0;
		wr_reg(8'h65, 8'h00); wr_reg(8'h63, 8'h00); wr_reg(8'h64, 8'h01);
		lo = 16; span = 1008;
		arm(8'h89, 8'h00);
		fin(2'b10, 8'hFF);
		// Open limits: repeat runs on with no fault until enable is cleared
		wr_reg(8'h63, 8'h0F);
		wr_reg(8'h64, 8'hFF);
		lo = 0;
		span = 1024;
		arm(8'h88, 8'h00);
		repeat (300) @(negedge clk);
		chk("busy", {15'h0, busy}, 16'h1);
		rc(8'h9A, 8'h00, 8'h30);
		wr_reg(8'h61, 8'h00);
		repeat (12) @(negedge clk);
		chk("busy", {15'h0, busy}, 16'h0);
		tally_and_finish;
	end
endmodule
bind adc_trigger_alu_limit_engine adc_engine_sva chk_u (.i_core_clk, .i_rst_n, .i_reg_rd,
	.i_reg_addr, .o_reg_rdata, .o_conv_start, .i_conv_done, .o_engine_busy, .o_engine_irq);
`default_nettype wire
